// [core/sscrc_generator.sv]
// Sample-set checksum generator over the fifteen output words
//
// Behaviour
// - Preset the accumulator to all ones at each sample set start.
// - Feed words in ascending list order, status first, sample_time_word last.
// - Invert the accumulator after the last word to form the result.
// - Recompute on every data-ready strobe; publish only when the pass ends before another strobe arrives.
// - Exactly fifteen words: status, temp, rate lo/hi, accel lo/hi, time.
// - Each word goes in as low byte then high byte, byte-wise updates.
// - Reflected Ethernet polynomial, right-shifting form.
// - Byte step by 256-entry table, equal to eight serial bit steps.
`timescale 1ns/1ps
module sscrc_generator (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Data-ready strobe of a new sample set
	input  wire logic                sampleReady,
	// Sample set words
	input  wire sscrc_pkg::sscrc_word_t statusWord,
	input  wire sscrc_pkg::sscrc_word_t tempWord,
	input  wire sscrc_pkg::sscrc_word_t rate_x_low_word,
	input  wire sscrc_pkg::sscrc_word_t rate_x_high_word,
	input  wire sscrc_pkg::sscrc_word_t rate_y_low_word,
	input  wire sscrc_pkg::sscrc_word_t rate_y_high_word,
	input  wire sscrc_pkg::sscrc_word_t rate_z_low_word,
	input  wire sscrc_pkg::sscrc_word_t rate_z_high_word,
	input  wire sscrc_pkg::sscrc_word_t accel_x_low_word,
	input  wire sscrc_pkg::sscrc_word_t accel_x_high_word,
	input  wire sscrc_pkg::sscrc_word_t accel_y_low_word,
	input  wire sscrc_pkg::sscrc_word_t accel_y_high_word,
	input  wire sscrc_pkg::sscrc_word_t accel_z_low_word,
	input  wire sscrc_pkg::sscrc_word_t accel_z_high_word,
	input  wire sscrc_pkg::sscrc_word_t sample_time_word,
	// Published result
	output      sscrc_pkg::sscrc_word_t checksum_low_half,
	output      sscrc_pkg::sscrc_word_t checksum_high_half,
	output      logic                crcUpdated,
	output      logic                crcBusy
);
	import sscrc_pkg::*;

	sscrc_word_t  inWords [WORD_COUNT];
	sscrc_word_t  words_reg [WORD_COUNT];
	sscrc_state_e state_reg;
	sscrc_state_e state_next;
	sscrc_crc_t   acc_reg;
	logic [4:0]   byteIdx_reg;
	sscrc_word_t  lowHalf_reg;
	sscrc_word_t  highHalf_reg;
	logic         updated_reg;
	sscrc_word_t  curWord;
	logic [7:0]   curByte;
	logic         lastByte;
	sscrc_crc_t   finalCrc;

	// the fifteen covered words in feed order
	assign inWords[IDX_STATUS]     = statusWord;
	assign inWords[IDX_TEMP]       = tempWord;
	assign inWords[IDX_RATE_X]     = rate_x_low_word;
	assign inWords[IDX_RATE_X + 1] = rate_x_high_word;
	assign inWords[IDX_RATE_Y]     = rate_y_low_word;
	assign inWords[IDX_RATE_Y + 1] = rate_y_high_word;
	assign inWords[IDX_RATE_Z]     = rate_z_low_word;
	assign inWords[IDX_RATE_Z + 1] = rate_z_high_word;
	assign inWords[IDX_ACCEL_X]    = accel_x_low_word;
	assign inWords[IDX_ACCEL_X + 1] = accel_x_high_word;
	assign inWords[IDX_ACCEL_Y]    = accel_y_low_word;
	assign inWords[IDX_ACCEL_Y + 1] = accel_y_high_word;
	assign inWords[IDX_ACCEL_Z]    = accel_z_low_word;
	assign inWords[IDX_ACCEL_Z + 1] = accel_z_high_word;
	assign inWords[IDX_TIME]       = sample_time_word;

	// byte counter selects the word in ascending order
	assign curWord  = words_reg[byteIdx_reg[4:1]];
	// even count takes the low byte, odd the high byte
	assign curByte  = byteIdx_reg[0] ? curWord[15:8] : curWord[7:0];
	assign lastByte = (byteIdx_reg == LAST_BYTE);
	assign finalCrc = acc_reg ^ CRC_XOR_OUT;

	// Byte update step
	sscrc_step_if stepBus ();
	assign stepBus.acc  = acc_reg;
	assign stepBus.data = curByte;

	sscrc_byte_step u_step (
		.clk  (clk),
		.rstn (rstn),
		.step (stepBus)
	);

	// Sequencer: a new strobe always restarts on the newest set
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: state_next = ST_IDLE;
			ST_RUN:  state_next = lastByte ? ST_DONE : ST_RUN;
			ST_DONE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
		if (sampleReady) begin
			state_next = ST_RUN;
		end
	end

	// Capture the sample set so it holds for the whole pass
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int w = 0; w < WORD_COUNT; w++) begin
				words_reg[w] <= 16'h0000;
			end
		end else if (sampleReady) begin
			words_reg <= inWords;
		end
	end

	// State, byte counter and accumulator
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg   <= ST_IDLE;
			byteIdx_reg <= 5'h00;
			acc_reg     <= CRC_PRESET;
		end else begin
			state_reg <= state_next;
			if (sampleReady) begin
				acc_reg     <= CRC_PRESET;
				byteIdx_reg <= 5'h00;
			end else if (state_reg == ST_RUN) begin
				acc_reg     <= stepBus.next;
				// Hold at the last byte so the word select stays in range
				byteIdx_reg <= lastByte ? byteIdx_reg : byteIdx_reg + 5'h01;
			end
		end
	end

	// publish both halves once per sample set whose pass ends with no new strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowHalf_reg  <= 16'h0000;
			highHalf_reg <= 16'h0000;
			updated_reg  <= 1'b0;
		end else begin
			updated_reg <= (state_reg == ST_DONE) && !sampleReady;
			if ((state_reg == ST_DONE) && !sampleReady) begin
				lowHalf_reg  <= finalCrc[15:0];
				highHalf_reg <= finalCrc[31:16];
			end
		end
	end

	// Outputs
	assign checksum_low_half  = lowHalf_reg;
	assign checksum_high_half = highHalf_reg;
	assign crcUpdated         = updated_reg;
	assign crcBusy            = (state_reg != ST_IDLE);

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_preset;
		sampleReady |=> (acc_reg == CRC_PRESET) && (byteIdx_reg == 5'h00);
	endproperty
	a_preset: assert property (p_preset)
		else $error("accumulator not preset at sample start");

	property p_ascending;
		(state_reg == ST_RUN) && !sampleReady && !lastByte
			|=> byteIdx_reg == $past(byteIdx_reg) + 5'h01;
	endproperty
	a_ascending: assert property (p_ascending)
		else $error("byte order not ascending");

	property p_invert;
		(state_reg == ST_DONE) && !sampleReady
			|=> {checksum_high_half, checksum_low_half}
				== ~$past(acc_reg);
	endproperty
	a_invert: assert property (p_invert)
		else $error("published value is not the inverted accumulator");

	property p_refresh;
		sampleReady ##1 !sampleReady[*8]
			|-> ##[1:30] (crcUpdated || sampleReady);
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("no fresh result after data ready");

	property p_fifteen_words;
		(state_reg == ST_RUN) && lastByte && !sampleReady
			|=> state_reg == ST_DONE;
	endproperty
	a_fifteen_words: assert property (p_fifteen_words)
		else $error("pass did not end after thirty bytes");

	property p_low_first;
		(state_reg == ST_RUN) && !byteIdx_reg[0] && !sampleReady
			|-> (curByte == curWord[7:0])
			##1 ((curWord == $past(curWord)) && (curByte == curWord[15:8]));
	endproperty
	a_low_first: assert property (p_low_first)
		else $error("byte of word taken in wrong order");

	property p_halves_change_on_update;
		!$stable({checksum_high_half, checksum_low_half}) |-> crcUpdated;
	endproperty
	a_halves_change_on_update: assert property (p_halves_change_on_update)
		else $error("result halves changed without update");

	c_full_pass: cover property (sampleReady ##32 crcUpdated);
	c_restart: cover property ((state_reg == ST_RUN) && sampleReady);
	c_back_to_back: cover property (crcUpdated ##[1:3] sampleReady);
endmodule // sscrc_generator

// [core/sscrc_pkg.sv]
// Shared constants for the sample-set checksum generator
package sscrc_pkg;
	typedef logic [15:0] sscrc_word_t;
	typedef logic [31:0] sscrc_crc_t;

	// Accumulator preset and final inversion mask
	localparam sscrc_crc_t CRC_PRESET   = 32'hffffffff;
	localparam sscrc_crc_t CRC_XOR_OUT  = 32'hffffffff;
	// Reflected Ethernet polynomial
	localparam sscrc_crc_t CRC_POLY_REF = 32'hedb88320;

	// Covered words and their position in the feed order
	localparam int          WORD_COUNT   = 15;
	localparam int          BYTE_COUNT   = 2 * WORD_COUNT;
	localparam int          TABLE_SIZE   = 256;
	localparam int          BITS_PER_BYTE = 8;
	localparam logic [4:0]  LAST_BYTE    = 5'(BYTE_COUNT - 1);
	localparam logic [3:0]  IDX_STATUS   = 4'h0;
	localparam logic [3:0]  IDX_TEMP     = 4'h1;
	localparam logic [3:0]  IDX_RATE_X   = 4'h2;
	localparam logic [3:0]  IDX_RATE_Y   = 4'h4;
	localparam logic [3:0]  IDX_RATE_Z   = 4'h6;
	localparam logic [3:0]  IDX_ACCEL_X  = 4'h8;
	localparam logic [3:0]  IDX_ACCEL_Y  = 4'ha;
	localparam logic [3:0]  IDX_ACCEL_Z  = 4'hc;
	localparam logic [3:0]  IDX_TIME     = 4'he;

	// Sequencer states, Gray coded along idle, run, done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} sscrc_state_e;

	// One reflected bit step
	function automatic sscrc_crc_t sscrc_bit_step(input sscrc_crc_t c);
		return c[0] ? ((c >> 1) ^ CRC_POLY_REF) : (c >> 1);
	endfunction

	// Eight reflected bit steps on a value
	function automatic sscrc_crc_t sscrc_eight_steps(input sscrc_crc_t c);
		sscrc_crc_t r;
		r = c;
		for (int b = 0; b < BITS_PER_BYTE; b++) begin
			r = sscrc_bit_step(r);
		end
		return r;
	endfunction
endpackage

// [core/sscrc_step_if.sv]
// Carrier between the sequencer and the byte update step
`timescale 1ns/1ps
interface sscrc_step_if;
	logic [31:0] acc;
	logic [7:0]  data;
	logic [31:0] next;

	modport user (output acc, output data, input next);
	modport calc (input acc, input data, output next);
endinterface // sscrc_step_if

// [core/sscrc_byte_step.sv]
// Table driven one-byte reflected checksum update
`timescale 1ns/1ps
module sscrc_byte_step (
	// Clock and reset, used by the checks only
	input wire logic    clk,
	input wire logic    rstn,
	// Update step
	sscrc_step_if.calc  step
);
	import sscrc_pkg::*;

	sscrc_crc_t crcTable [TABLE_SIZE];
	logic [7:0] tableIdx;

	for (genvar i = 0; i < TABLE_SIZE; i++) begin : g_table
		assign crcTable[i] = sscrc_eight_steps(sscrc_crc_t'(i));
	end

	assign tableIdx  = step.acc[7:0] ^ step.data;
	assign step.next = (step.acc >> 8) ^ crcTable[tableIdx];

	// Bit-serial reference, only for the checks
	sscrc_crc_t serialRef;
	assign serialRef = sscrc_eight_steps(step.acc ^ {24'h000000, step.data});

	property p_table_equals_serial;
		@(posedge clk) disable iff (!rstn)
		step.next == serialRef;
	endproperty
	a_table_equals_serial: assert property (p_table_equals_serial)
		else $error("table step differs from bit-serial step");

	property p_poly_term;
		@(posedge clk) disable iff (!rstn)
		(tableIdx == 8'h80) |-> step.next == ((step.acc >> 8) ^ CRC_POLY_REF);
	endproperty
	a_poly_term: assert property (p_poly_term)
		else $error("reflected polynomial not applied");
endmodule // sscrc_byte_step

// [tb/sscrc_host_model.sv]
// Host model that reads the published checksum halves
`timescale 1ns/1ps
module sscrc_host_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Published result seen by the host
	input  wire logic [15:0] lowHalf,
	input  wire logic [15:0] highHalf,
	input  wire logic        updated,
	// Last value read and number of reads
	output logic [31:0]      readCrc,
	output int               readCount
);
	// reads within cycle
	// Reads both halves in the cycle the update shows
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			readCrc   <= 32'h00000000;
			readCount <= 0;
		end else if (updated) begin
			readCrc   <= {highHalf, lowHalf};
			readCount <= readCount + 1;
		end
	end
endmodule // sscrc_host_model

// [tb/sscrc_generator_tb_top.sv]
// Self-checking testbench of the sample-set checksum generator
`timescale 1ns/1ps
module sscrc_generator_tb_top;
	import sscrc_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        sampleReady = 1'b0;
	sscrc_word_t w [15];
	sscrc_word_t loH, hiH;
	logic        upd, busy;
	logic [31:0] hostCrc;
	int          hostCount;
	int          err_total = 0;
	int          check_count = 0;

	// Clock of 10 ns period
	always #5 clk = ~clk;

	sscrc_generator i_dut (.clk(clk), .rstn(rstn), .sampleReady(sampleReady),
		.statusWord(w[0]), .tempWord(w[1]),
		.rate_x_low_word(w[2]), .rate_x_high_word(w[3]),
		.rate_y_low_word(w[4]), .rate_y_high_word(w[5]),
		.rate_z_low_word(w[6]), .rate_z_high_word(w[7]),
		.accel_x_low_word(w[8]), .accel_x_high_word(w[9]),
		.accel_y_low_word(w[10]), .accel_y_high_word(w[11]),
		.accel_z_low_word(w[12]), .accel_z_high_word(w[13]),
		.sample_time_word(w[14]), .checksum_low_half(loH),
		.checksum_high_half(hiH), .crcUpdated(upd), .crcBusy(busy));

	sscrc_host_model i_host (.clk(clk), .rstn(rstn), .lowHalf(loH),
		.highHalf(hiH), .updated(upd), .readCrc(hostCrc),
		.readCount(hostCount));

	// Bit-serial reference over the current words, low bit first
	function automatic logic [31:0] ref_crc();
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < 15; i++) begin
			for (int b = 0; b < 16; b++) begin
				c = ((c[0] ^ w[i][b]) == 1'b1) ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
			end
		end
		return ~c;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pulse();
		@(posedge clk);
		#1 sampleReady = 1'b1;
		@(posedge clk);
		#1 sampleReady = 1'b0;
	endtask

	// Counts edges from the strobe to the edge that samples the update
	task automatic wait_done(output int n);
		n = 1;
		while (n < 40) begin
			@(posedge clk);
			#1 n++;
			if (n == 2) cmp(32'(busy), 32'h1);
			if (upd === 1'b1) break;
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic t_reference();
		int n;
		w = '{16'h0000, 16'h083a, 16'h0000, 16'hfff7, 16'h0000, 16'hfffe,
			16'h0000, 16'h0001, 16'h5001, 16'h0003, 16'he00a, 16'h0015,
			16'hc009, 16'h0320, 16'h8a54};
		pulse();
		wait_done(n);
		cmp(n, 32);
		cmp(32'(busy), 32'h0);
		cmp({hiH, loH}, 32'hb6c815b4);
		@(posedge clk);
		#1 cmp(32'(upd), 32'h0);
		cmp(hostCrc, 32'hb6c815b4);
		cmp(32'(hostCount), 32'h1);
		$display("test reference done");
	endtask

	task automatic t_capture_b2b();
		int n;
		logic [31:0] e;
		for (int i = 0; i < 15; i++) w[i] = 16'(i * 16'h1357 + 16'h00ff);
		e = ref_crc();
		pulse();
		for (int i = 0; i < 15; i++) w[i] = 16'hffff;
		wait_done(n);
		cmp({hiH, loH}, e);
		e = ref_crc();
		pulse();
		wait_done(n);
		cmp(n, 32);
		cmp({hiH, loH}, e);
		$display("test capture and back to back done");
	endtask

	task automatic t_abort();
		int n;
		logic [31:0] e;
		for (int i = 0; i < 15; i++) w[i] = 16'(16'ha5a5 ^ (i << 4));
		pulse();
		repeat (9) @(posedge clk);
		#1 w[14] = 16'h0001;
		e = ref_crc();
		pulse();
		wait_done(n);
		cmp(n, 32);
		cmp({hiH, loH}, e);
		$display("test restart done");
	endtask

	task automatic t_reset();
		pulse();
		repeat (5) @(posedge clk);
		#1 rstn = 1'b0;
		#1 cmp({hiH, loH}, 32'h0);
		cmp(32'({busy, upd}), 32'h0);
		cmp(32'(hostCount), 32'h0);
		@(posedge clk);
		#1 rstn = 1'b1;
		repeat (40) @(posedge clk);
		#1 cmp(32'(upd), 32'h0);
		cmp({hiH, loH}, 32'h0);
		$display("test reset done");
	endtask

	// Main sequence
	initial begin
		for (int i = 0; i < 15; i++) w[i] = 16'h0000;
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		cmp({hiH, loH}, 32'h0);
		t_reference();
		t_capture_b2b();
		t_abort();
		t_reset();
		conclude();
	end

	// Watchdog against a hang
	initial begin
		#(5000 * 10);
		err_total++;
		conclude();
	end
endmodule // sscrc_generator_tb_top
